// File: hsp_board_model.sv
// board model: strap resistors, shared pin wire and reset source
module hsp_board_model
	import hsp_pkg::*;
(
	// bench requests
	input  wire logic core_clk,
	input  wire logic reset_req,
	input  wire logic strap_low,
	input  wire logic strap_high,
	input  wire logic cfg_sel,
	// device pins
	input  wire logic hub_active_indicator,
	input  wire logic shared_pin_oe,
	output logic      nrst,
	output logic      shared_pin_in,
	output logic      fixed_port_strap_high,
	output logic      config_select_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned low_cnt = 0;
	// a short request is stretched, so the chip never sees a pulse below the least width
	always_ff @(posedge core_clk) begin
		if (reset_req)
			low_cnt <= HSP_RESET_MIN_CYC;
		else if (low_cnt != 0)
			low_cnt <= low_cnt - 1;
	end
	assign nrst = !(reset_req || low_cnt != 0);
	// the strap resistor sets the wire whenever the device lets go of it
	assign shared_pin_in = shared_pin_oe ? hub_active_indicator : strap_low;
	assign fixed_port_strap_high = strap_high;
	assign config_select_in = cfg_sel;
endmodule

// File: hsp_pkg.sv
// constants and types shared by the strap and status pin logic
package hsp_pkg;

	timeunit 1ns;
	timeprecision 1ps;

	// apb register map
	localparam int unsigned HSP_ADDR_W      = 8;
	localparam logic [7:0]  HSP_OFS_CONFIG  = 8'h00;
	localparam logic [7:0]  HSP_OFS_STATCMD = 8'h04;
	localparam logic [7:0]  HSP_OFS_STRAPS  = 8'h08;

	// config_byte_two field positions
	localparam int unsigned HSP_CFG_DYN_BIT    = 0;
	localparam int unsigned HSP_CFG_STATIC_BIT = 1;

	// status_command_reg field positions
	localparam int unsigned HSP_SC_ATTACH_BIT = 0;

	// strap status field positions
	localparam int unsigned HSP_ST_CODE_LSB  = 0;
	localparam int unsigned HSP_ST_SMBUS_BIT = 2;
	localparam int unsigned HSP_ST_SPWR_BIT  = 3;
	localparam int unsigned HSP_ST_RPT_BIT   = 4;
	localparam int unsigned HSP_ST_ACT_BIT   = 5;
	localparam int unsigned HSP_ST_VALID_BIT = 6;
	localparam int unsigned HSP_ST_RSVD_BIT  = 7;
	localparam int unsigned HSP_ST_NREM_LSB  = 8;

	// synchronised pin bundle positions
	localparam int unsigned HSP_PIN_W      = 3;
	localparam int unsigned HSP_PIN_SHARED = 0;
	localparam int unsigned HSP_PIN_HIGH   = 1;
	localparam int unsigned HSP_PIN_CFGSEL = 2;

	// configuration select level that means smbus configuration
	localparam logic HSP_CFGSEL_SMBUS = 1'b1;

	// fixed port codes
	localparam logic [1:0] HSP_CODE_NONE = 2'h0;
	localparam logic [1:0] HSP_CODE_P1   = 2'h1;
	localparam logic [1:0] HSP_CODE_P12  = 2'h2;
	localparam logic [1:0] HSP_NREM_NONE = 2'h0;
	localparam logic [1:0] HSP_NREM_P1   = 2'h1;
	localparam logic [1:0] HSP_NREM_P12  = 2'h3;

	// values after reset
	localparam logic        HSP_DYN_RST    = 1'b0;
	localparam logic        HSP_STATIC_RST = 1'b0;
	localparam logic        HSP_ATTACH_RST = 1'b0;
	localparam logic [31:0] HSP_RDATA_RST  = 32'h0000_0000;

	// timing: core clock period and least chip reset pulse
	localparam int unsigned HSP_CLK_PERIOD_NS  = 8;
	localparam int unsigned HSP_RESET_MIN_NS   = 1000;
	localparam int unsigned HSP_RESET_MIN_CYC  =
		(HSP_RESET_MIN_NS + HSP_CLK_PERIOD_NS - 1) / HSP_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		HSP_PH_SAMPLE,
		HSP_PH_DETACHED,
		HSP_PH_ATTACHED
	} hsp_phase_t;

endpackage

// File: hsp_strap_capture.sv
// captures a level at the first clock after reset release and holds it
module hsp_strap_capture #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// level to capture
	input  wire logic [WIDTH-1:0] sample_in,
	// held value
	output logic      [WIDTH-1:0] held_out,
	output logic                  held_valid
);

	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [WIDTH-1:0] value;
		logic             valid;
	} hsp_cap_state_t;

	hsp_cap_state_t q;
	hsp_cap_state_t d;

	always_comb begin
		d = q;
		if (!q.valid) begin
			d.value = sample_in;
			d.valid = 1'b1;
		end
		if (!nrst) begin
			d.value = '0;
			d.valid = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign held_out   = q.value;
	assign held_valid = q.valid;

endmodule

// File: hsp_strap_pins.sv
// strap sampling, shared status/power pin and apb registers of the hub pin block
//
// Chosen here: the register addresses and the APB slave port.

module hsp_strap_pins
	import hsp_pkg::*;
(
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  nrst,

	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [HSP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,

	// shared pin: strap low, self power sense or active indicator
	input  wire logic                  shared_pin_in,
	output logic                       hub_active_indicator,
	output logic                       shared_pin_oe,

	// other strap pins
	input  wire logic                  fixed_port_strap_high,
	input  wire logic                  config_select_in,

	// hub core state
	input  wire logic                  hub_configured,
	input  wire logic                  hub_suspended,

	// results towards the hub core
	output logic                       attach_command,
	output logic                       self_powered_report,
	output logic                       self_power_present,
	output logic      [1:0]            fixed_port_code,
	output logic      [1:0]            port_non_removable,
	output logic                       fixed_port_code_reserved,
	output logic                       smbus_config_mode,
	output logic                       straps_valid
);

	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		hsp_phase_t  phase;
		logic        mode_smbus;
		logic        attach;
		logic        dyn_en;
		logic        static_sp;
		logic        self_power;
		logic        report_sp;
		logic [1:0]  code;
		logic [1:0]  nonrem;
		logic        code_rsvd;
		logic        pin_oe;
		logic        pin_out;
		logic [31:0] rdata;
		logic        slverr;
	} hsp_state_t;

	hsp_state_t q;
	hsp_state_t d;

	logic [HSP_PIN_W-1:0] pin_sync;
	logic [HSP_PIN_W-1:0] strap_val;
	logic                 strap_ok;
	logic                 apb_setup;
	logic                 apb_access;
	logic                 wr_cfg;
	logic                 wr_statcmd;
	logic                 smbus_sel;
	logic [1:0]           code_now;

	// every pin passes two flops before anything looks at it
	hsp_sync #(
		.WIDTH (HSP_PIN_W)
	) u_pin_sync (
		.core_clk (core_clk),
		.async_in ({config_select_in, fixed_port_strap_high, shared_pin_in}),
		.sync_out (pin_sync)
	);

	// straps are taken once, at the first edge after release
	hsp_strap_capture #(
		.WIDTH (HSP_PIN_W)
	) u_strap_cap (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.sample_in  (pin_sync),
		.held_out   (strap_val),
		.held_valid (strap_ok)
	);

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign smbus_sel  = (strap_val[HSP_PIN_CFGSEL] == HSP_CFGSEL_SMBUS);
	assign code_now   = {strap_val[HSP_PIN_HIGH], strap_val[HSP_PIN_SHARED]};

	// low byte lane carries every writable bit
	assign wr_cfg     = apb_access & pwrite & pstrb[0] & (paddr == HSP_OFS_CONFIG);
	assign wr_statcmd = apb_access & pwrite & pstrb[0] & (paddr == HSP_OFS_STATCMD);

	always_comb begin
		d = q;

		// straps, attach tracking and self power sampling
		case (q.phase)
			HSP_PH_SAMPLE: begin
				if (strap_ok) begin
					d.phase      = HSP_PH_DETACHED;
					d.mode_smbus = smbus_sel;
					d.self_power = smbus_sel & strap_val[HSP_PIN_SHARED];
					// under smbus both strap pins belong to the bus, so no fixed ports
					if (smbus_sel) begin
						d.code = HSP_CODE_NONE;
					end else begin
						d.code = code_now;
					end
				end
			end
			HSP_PH_DETACHED: begin
				// keep following the sense input until the hub attaches;
				// the attach flag stops tracking in the very cycle it shows
				if (q.mode_smbus & ~q.attach) begin
					d.self_power = pin_sync[HSP_PIN_SHARED];
				end
				if (q.attach) begin
					d.phase = HSP_PH_ATTACHED;
				end
			end
			HSP_PH_ATTACHED: begin
				d.self_power = q.self_power;
			end
			default: begin
				d.phase = HSP_PH_SAMPLE;
			end
		endcase

		// decoded from the next code, so map and code change on the same edge
		if (d.code == HSP_CODE_P1) begin
			d.nonrem    = HSP_NREM_P1;
			d.code_rsvd = 1'b0;
		end else if (d.code == HSP_CODE_P12) begin
			d.nonrem    = HSP_NREM_P12;
			d.code_rsvd = 1'b0;
		end else if (d.code == HSP_CODE_NONE) begin
			d.nonrem    = HSP_NREM_NONE;
			d.code_rsvd = 1'b0;
		end else begin
			// reserved code: treat all ports as removable and flag it
			d.nonrem    = HSP_NREM_NONE;
			d.code_rsvd = 1'b1;
		end

		// power report: with dyn_en a low sense level means bus powered, else static_sp gives it
		if (q.dyn_en) begin
			d.report_sp = q.self_power;
		end else begin
			d.report_sp = q.static_sp;
		end

		// shared pin drives the indicator only after release under strap config
		// uses the next phase and mode so the pin is driven as soon as straps show valid
		d.pin_oe  = (d.phase != HSP_PH_SAMPLE) & ~d.mode_smbus;
		d.pin_out = d.pin_oe & hub_configured & ~hub_suspended;

		// register writes take effect in the access phase
		if (wr_cfg) begin
			d.dyn_en    = pwdata[HSP_CFG_DYN_BIT];
			d.static_sp = pwdata[HSP_CFG_STATIC_BIT];
		end
		// attach is set only; detaching needs a chip reset, so the frozen value stays frozen
		if (wr_statcmd & pwdata[HSP_SC_ATTACH_BIT]) begin
			d.attach = 1'b1;
		end

		// read data and error are prepared in the setup phase for a fixed one-cycle answer
		if (apb_setup) begin
			d.rdata  = HSP_RDATA_RST;
			d.slverr = 1'b0;
			if (paddr == HSP_OFS_CONFIG) begin
				d.rdata[HSP_CFG_DYN_BIT]    = q.dyn_en;
				d.rdata[HSP_CFG_STATIC_BIT] = q.static_sp;
			end else if (paddr == HSP_OFS_STATCMD) begin
				d.rdata[HSP_SC_ATTACH_BIT] = q.attach;
			end else if (paddr == HSP_OFS_STRAPS) begin
				d.rdata[HSP_ST_CODE_LSB +: 2]  = q.code;
				d.rdata[HSP_ST_SMBUS_BIT]      = q.mode_smbus;
				d.rdata[HSP_ST_SPWR_BIT]       = q.self_power;
				d.rdata[HSP_ST_RPT_BIT]        = q.report_sp;
				d.rdata[HSP_ST_ACT_BIT]        = q.pin_out;
				d.rdata[HSP_ST_VALID_BIT]      = (q.phase != HSP_PH_SAMPLE);
				d.rdata[HSP_ST_RSVD_BIT]       = q.code_rsvd;
				d.rdata[HSP_ST_NREM_LSB +: 2]  = q.nonrem;
			end else begin
				d.slverr = 1'b1;
			end
		end

		// synchronous reset returns every field to its idle value
		if (!nrst) begin
			d.phase      = HSP_PH_SAMPLE;
			d.mode_smbus = 1'b0;
			d.attach     = HSP_ATTACH_RST;
			d.dyn_en     = HSP_DYN_RST;
			d.static_sp  = HSP_STATIC_RST;
			d.self_power = 1'b0;
			d.report_sp  = 1'b0;
			d.code       = HSP_CODE_NONE;
			d.nonrem     = HSP_NREM_NONE;
			d.code_rsvd  = 1'b0;
			d.pin_oe     = 1'b0;
			d.pin_out    = 1'b0;
			d.rdata      = HSP_RDATA_RST;
			d.slverr     = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	// zero wait states: every access phase completes at once
	assign pready  = apb_access;
	assign prdata  = q.rdata;
	assign pslverr = apb_access & q.slverr;

	assign hub_active_indicator     = q.pin_out;
	assign shared_pin_oe            = q.pin_oe;
	assign attach_command           = q.attach;
	assign self_powered_report      = q.report_sp;
	assign self_power_present       = q.self_power;
	assign fixed_port_code          = q.code;
	assign port_non_removable       = q.nonrem;
	assign fixed_port_code_reserved = q.code_rsvd;
	assign smbus_config_mode        = q.mode_smbus;
	assign straps_valid             = (q.phase != HSP_PH_SAMPLE);

endmodule

// File: hsp_strap_pins_checker.sv
// assertions on the ports of the strap and status pin block
module hsp_strap_pins_checker
	import hsp_pkg::*;
(
	// watched ports
	input wire logic                  core_clk,
	input wire logic                  nrst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [HSP_ADDR_W-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic                  hub_active_indicator,
	input wire logic                  shared_pin_oe,
	input wire logic                  hub_configured,
	input wire logic                  hub_suspended,
	input wire logic                  attach_command,
	input wire logic                  self_powered_report,
	input wire logic                  self_power_present,
	input wire logic [1:0]            fixed_port_code,
	input wire logic [1:0]            port_non_removable,
	input wire logic                  fixed_port_code_reserved,
	input wire logic                  smbus_config_mode,
	input wire logic                  straps_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// config bits mirrored from bus writes, so the report choice can be predicted
	logic [1:0] cfg_q;
	always_ff @(posedge core_clk) begin
		if (!nrst)
			cfg_q <= 2'h0;
		else if (psel && penable && pwrite && paddr == HSP_OFS_CONFIG && pstrb[0])
			cfg_q <= pwdata[1:0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_ind_follow: assert property (straps_valid && !smbus_config_mode |=>
		hub_active_indicator == $past(hub_configured && !hub_suspended)) else $error("indicator");
	a_smbus_quiet: assert property (smbus_config_mode |->
		!hub_active_indicator && !shared_pin_oe) else $error("pin driven in smbus mode");
	a_strap_drive: assert property (straps_valid && !smbus_config_mode |->
		shared_pin_oe) else $error("pin not driven in strap mode");
	a_strap_nopower: assert property (!smbus_config_mode |->
		!self_power_present) else $error("self power in strap mode");
	a_code_map: assert property (straps_valid |->
		port_non_removable == (fixed_port_code == HSP_CODE_P1 ? HSP_NREM_P1 :
		fixed_port_code == HSP_CODE_P12 ? HSP_NREM_P12 : HSP_NREM_NONE) &&
		fixed_port_code_reserved == (fixed_port_code == 2'h3)) else $error("port map");
	a_mode_code: assert property (smbus_config_mode |->
		fixed_port_code == HSP_CODE_NONE) else $error("code in smbus mode");
	a_straps_hold: assert property (straps_valid && $past(straps_valid) |->
		$stable(fixed_port_code) && $stable(smbus_config_mode)) else $error("straps moved");
	a_power_frozen: assert property (attach_command && $past(attach_command) |->
		$stable(self_power_present)) else $error("power moved after attach");
	a_report_pick: assert property (straps_valid && $past(straps_valid) &&
		$stable(cfg_q) && $stable(self_power_present) |-> self_powered_report ==
		(cfg_q[HSP_CFG_DYN_BIT] ? self_power_present : cfg_q[HSP_CFG_STATIC_BIT]))
		else $error("power report");
endmodule
bind hsp_strap_pins hsp_strap_pins_checker i_hsp_strap_pins_checker (.core_clk, .nrst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .hub_active_indicator, .shared_pin_oe,
	.hub_configured, .hub_suspended, .attach_command, .self_powered_report, .self_power_present,
	.fixed_port_code, .port_non_removable, .fixed_port_code_reserved, .smbus_config_mode,
	.straps_valid);

// File: hsp_strap_pins_tb_top.sv
// self-checking bench of the strap and status pin block
module hsp_strap_pins_tb_top
	import hsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic c, h, l, rsv; logic [1:0] code, map;} hsp_row_t;
	hsp_row_t rows [5] = '{'{1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 2'h0},
		'{1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 2'h1}, '{1'h0, 1'h1, 1'h0, 1'h0, 2'h2, 2'h3},
		'{1'h0, 1'h1, 1'h1, 1'h1, 2'h3, 2'h0}, '{1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 2'h0}};
	logic        core_clk = 1'h0, reset_req = 1'h1, strap_low = 1'h0, strap_high = 1'h0;
	logic        cfg_sel = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        hub_configured = 1'h0, hub_suspended = 1'h0, nrst, pready, pslverr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  pstrb = 4'h0;
	logic        shared_pin_in, hub_active_indicator, shared_pin_oe, fixed_port_strap_high;
	logic        config_select_in, attach_command, self_powered_report, self_power_present;
	logic        fixed_port_code_reserved, smbus_config_mode, straps_valid;
	logic [1:0]  fixed_port_code, port_non_removable;
	int          errors = 0, checks_done = 0;
	always #4 core_clk = ~core_clk;
	hsp_board_model i_hsp_board_model (.core_clk, .reset_req, .strap_low, .strap_high, .cfg_sel,
		.hub_active_indicator, .shared_pin_oe, .nrst, .shared_pin_in, .fixed_port_strap_high,
		.config_select_in);
	hsp_strap_pins i_hsp_strap_pins (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .shared_pin_in, .hub_active_indicator, .shared_pin_oe,
		.fixed_port_strap_high, .config_select_in, .hub_configured, .hub_suspended,
		.attach_command, .self_powered_report, .self_power_present, .fixed_port_code,
		.port_non_removable, .fixed_port_code_reserved, .smbus_config_mode, .straps_valid);
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
	endtask
	// this task changes the straps only while reset is held, so they are settled long before release
	task automatic reboot(logic c, logic h, logic l);
		int i;
		reset_req <= 1'h1;
		cfg_sel <= c;
		strap_high <= h;
		strap_low <= l;
		tick(8);
		reset_req <= 1'h0;
		for (i = 0; i < 400 && straps_valid !== 1'h1; i++)
			tick(1);
		if (i == 400) begin
			errors++;
			final_report();
		end
		tick(1);
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [31:0] xr,
			logic xe);
		int i;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		tick(1);
		penable <= 1'h1;
		for (i = 0; i < 16; i++) begin
			tick(1);
			if (pready === 1'h1)
				break;
		end
		if (i == 16) begin
			errors++;
			final_report();
		end
		if (!w)
			chk("prdata", xr, prdata);
		chk("pslverr", xe, pslverr);
		psel <= 1'h0;
		penable <= 1'h0;
		tick(1);
	endtask
	initial begin
		foreach (rows[k]) begin
			reboot(rows[k].c, rows[k].h, rows[k].l);
			chk("code", rows[k].code, fixed_port_code);
			chk("map", rows[k].map, port_non_removable);
			chk("reserved", rows[k].rsv, fixed_port_code_reserved);
			chk("mode", rows[k].c, smbus_config_mode);
			chk("oe", !rows[k].c, shared_pin_oe);
			apb(1'h0, HSP_OFS_STRAPS, 32'h0, 4'h0, {22'h0, rows[k].map, rows[k].rsv, 3'h4,
				rows[k].c & rows[k].l, rows[k].c, rows[k].code}, 1'h0);
			$display("row %0d done", k);
		end
		reboot(1'h0, 1'h0, 1'h1);
		for (int k = 0; k < 4; k++) begin
			hub_configured <= k[0];
			hub_suspended <= k[1];
			tick(2);
			chk("indicator", k[0] & !k[1], hub_active_indicator);
		end
		strap_high <= 1'h1;
		tick(4);
		chk("held code", 2'h1, fixed_port_code);
		$display("strap test done");
		hub_suspended <= 1'h0;
		reboot(1'h1, 1'h0, 1'h0);
		apb(1'h0, HSP_OFS_CONFIG, 32'h0, 4'h0, 32'h0, 1'h0);
		apb(1'h0, HSP_OFS_STATCMD, 32'h0, 4'h0, 32'h0, 1'h0);
		chk("power low", 1'h0, self_power_present);
		chk("smbus indicator", 1'h0, hub_active_indicator);
		apb(1'h1, HSP_OFS_CONFIG, 32'h1, 4'h1, 32'h0, 1'h0);
		strap_low <= 1'h1;
		tick(6);
		chk("power sense", 1'h1, self_power_present);
		chk("report dyn", 1'h1, self_powered_report);
		apb(1'h1, HSP_OFS_CONFIG, 32'h2, 4'h0, 32'h0, 1'h0);
		apb(1'h1, HSP_OFS_STRAPS, 32'h0, 4'h1, 32'h0, 1'h0);
		apb(1'h0, HSP_OFS_CONFIG, 32'h0, 4'h0, 32'h1, 1'h0);
		apb(1'h1, HSP_OFS_STATCMD, 32'h1, 4'h1, 32'h0, 1'h0);
		strap_low <= 1'h0;
		tick(6);
		chk("frozen power", 1'h1, self_power_present);
		chk("frozen report", 1'h1, self_powered_report);
		apb(1'h0, 8'h0c, 32'h0, 4'h0, 32'h0, 1'h1);
		$display("smbus test done");
		reboot(1'h1, 1'h0, 1'h0);
		chk("attach cleared", 1'h0, attach_command);
		apb(1'h1, HSP_OFS_CONFIG, 32'h2, 4'h1, 32'h0, 1'h0);
		tick(2);
		chk("report static", 1'h1, self_powered_report);
		$display("static report test done");
		final_report();
	end
endmodule

// File: hsp_sync.sv
// two flip-flop synchroniser for pin inputs
module hsp_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock
	input  wire logic             core_clk,
	// pins
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised levels
	output logic      [WIDTH-1:0] sync_out
);

	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} hsp_sync_state_t;

	hsp_sync_state_t q;
	hsp_sync_state_t d;

	// no reset: the chain keeps following the pins during reset so straps are settled at release
	always_comb begin
		d        = q;
		d.meta   = async_in;
		d.stable = q.meta;
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign sync_out = q.stable;

endmodule
